// File: bench/scs_clk_model.sv
// Purpose: free-running clock sources that feed the selector pins
// Assumes: edges sit 7 ns after a 20 ns grid, clear of the sampling edge
// Notes:   each source has its own high and low time so modes are told apart
`default_nettype none

module scs_clk_model #(
    parameter int HI [5] = '{40, 120, 60, 60, 40},
    parameter int LO [5] = '{100, 120, 60, 100, 60}
) (
    output var scs_pkg::scs_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] w;

    // bit order: direct, crystal, internal, wakeup, pll from the top
    assign pins = w;
    for (genvar i = 0; i < 5; i++)
    begin : g_src
        initial
        begin
            w[4-i] = 1'b0;
            #7;
            forever
            begin
                w[4-i] = 1'b1;
                #(HI[i]);
                w[4-i] = 1'b0;
                #(LO[i]);
            end
        end
    end
endmodule

`default_nettype wire

// File: bench/scs_clock_select_tb_top.sv
// Purpose: self-checking bench for the system clock source selector
// Assumes: sources from scs_clk_model; times counted in 20 ns samples
// Notes:   waveforms checked by measured high, low and period counts
`default_nettype none

module scs_clock_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk;
    logic               rst;
    scs_pkg::scs_cfg_s  cfg;
    scs_pkg::scs_pins_s pins;
    logic               sys_clock;
    logic               pll_enable;
    scs_pkg::scs_mode_e sys_clock_mode;
    int                 fails;
    int                 n_checks;
    int                 f;
    logic               o;
    int                 tbl [4] = '{1, 2, 3, 1024};

    scs_clk_model u_src (.pins(pins));
    scs_clock_select DUT (.clk(clk), .rst(rst), .cfg(cfg), .pins(pins),
        .sys_clock(sys_clock), .pll_enable(pll_enable), .sys_clock_mode(sys_clock_mode));

    // 50 MHz sampling clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // expected decode of a configuration
    function automatic scs_pkg::scs_mode_e exp_mode(input logic [1:0] s, input logic b);
        if (s == scs_pkg::SEL_DIRECT) return scs_pkg::MODE_DIRECT;
        if (s == scs_pkg::SEL_WAKEUP) return scs_pkg::MODE_WAKEUP;
        if (s == scs_pkg::SEL_RESERVED) return scs_pkg::MODE_RESERVED;
        return b ? scs_pkg::MODE_PRESCALE : scs_pkg::MODE_PLL;
    endfunction

    task automatic set_cfg(input logic [1:0] s, input logic b, input logic os, input int fac);
        @(posedge clk);
        #1;
        cfg = '{s, b, os, 10'(fac - 1)};
        repeat (3) @(posedge clk);
        #1;
        chk("mode", 32'(exp_mode(s, b)), 32'(sys_clock_mode));
        chk("pll_enable", 32'(exp_mode(s, b) == scs_pkg::MODE_PLL), 32'(pll_enable));
    endtask

    task automatic wait_lvl(input logic v);
        int t;
        t = 0;
        while (sys_clock !== v && t < 20000)
        begin
            @(posedge clk);
            #1;
            t++;
        end
        if (t >= 20000) chk("edge wait", 32'(v), 32'(sys_clock));
    endtask

    // one whole period after a settling period; hi checked when asked
    task automatic measure(input string nm, input int hi, input int per, input bit do_hi);
        int h;
        int l;
        h = 0;
        l = 0;
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        while (sys_clock === 1'b1 && h < 20000) begin @(posedge clk); #1; h++; end
        while (sys_clock === 1'b0 && l < 20000) begin @(posedge clk); #1; l++; end
        chk({nm, " period"}, 32'(per), 32'(h + l));
        if (do_hi) chk({nm, " high"}, 32'(hi), 32'(h));
        $display("test %s done", nm);
    endtask

    initial
    begin
        #(90000 * 20);
        fails++;
        end_sim();
    end

    initial
    begin
        rst = 1'b1;
        cfg = '0;
        void'($urandom(32'h0134));
        repeat (6) @(posedge clk);
        #1;
        chk("rst sys_clock", 32'(scs_pkg::SYS_CLOCK_RST), 32'(sys_clock));
        chk("rst mode", 32'(scs_pkg::MODE_WAKEUP), 32'(sys_clock_mode));
        rst = 1'b0;
        set_cfg(scs_pkg::SEL_DIRECT, 1'b0, 1'b0, 1);
        measure("direct", 2, 7, 1);
        set_cfg(scs_pkg::SEL_WAKEUP, 1'b0, 1'b0, 1);
        measure("wakeup", 3, 8, 1);
        set_cfg(scs_pkg::SEL_PLL_PRESC, 1'b0, 1'b0, 5);
        measure("pll", 2, 5, 1);
        set_cfg(scs_pkg::SEL_RESERVED, 1'b1, 1'b0, 1);
        repeat (20) begin @(posedge clk); #1; chk("reserved", 32'h0, 32'(sys_clock)); end
        $display("test reserved done");
        // fixed factors on the crystal, then random ones on either source
        for (int k = 0; k < 8; k++)
        begin
            f = (k < 4) ? tbl[k] : $urandom_range(1, 40);
            o = (k < 4) ? 1'b0 : 1'($urandom_range(0, 1));
            set_cfg(scs_pkg::SEL_PLL_PRESC, 1'b1, o, f);
            measure("prescale", f * (o ? 3 : 6), f * (o ? 6 : 12), 1'b1);
        end
        // second reset in mid-run
        @(posedge clk);
        #1;
        rst = 1'b1;
        #2;
        chk("rerst pll_enable", 32'(scs_pkg::PLL_ENABLE_RST), 32'(pll_enable));
        chk("rerst sys_clock", 32'(scs_pkg::SYS_CLOCK_RST), 32'(sys_clock));
        $display("test reset done");
        end_sim();
    end
endmodule

`default_nettype wire

// File: hdl/scs_clock_select.sv
// Purpose: selects and derives the system clock from the available sources
// Assumes: sources are sampled at 50 MHz; cfg is synchronous to clk
// Notes:   output is a sampled waveform, delayed by the synchroniser and one register, plus the half-period counter register when dividing
//
// Overview of operation
// - select 11 takes direct clock input
// - direct mode follows input frequency and duty
// - prescaler active at select 10, bypass 1
// - divides crystal or internal by value+1
// - factor one follows oscillator duty cycle
// - maximum divide factor is 1024
// - crystal bypass, factor one equals direct drive
// - select 10, bypass 0 enables pll
// - select 00 takes wakeup clock
`default_nettype none

module scs_clock_select (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire scs_pkg::scs_cfg_s  cfg,
    input  wire scs_pkg::scs_pins_s pins,
    output logic                    sys_clock,
    output logic                    pll_enable,
    output scs_pkg::scs_mode_e      sys_clock_mode
);

    // mode decode from select field and bypass bit
    function automatic scs_pkg::scs_mode_e decode_mode(input logic [1:0] sel,
                                                        input logic       bypass);
        scs_pkg::scs_mode_e m;
        case (sel)
            scs_pkg::SEL_DIRECT:    m = scs_pkg::MODE_DIRECT;
            scs_pkg::SEL_PLL_PRESC: m = (bypass == scs_pkg::VCO_BYPASS_ON) ?
                                        scs_pkg::MODE_PRESCALE : scs_pkg::MODE_PLL;
            scs_pkg::SEL_WAKEUP:    m = scs_pkg::MODE_WAKEUP;
            default:                m = scs_pkg::MODE_RESERVED;
        endcase
        return m;
    endfunction

    // divide factor is the ten-bit value plus one
    function automatic logic [scs_pkg::FACTOR_W-1:0] div_factor(
        input logic [scs_pkg::PRESC_W-1:0] value);
        return {1'b0, value} + 11'h001;
    endfunction

    scs_pkg::scs_pins_s                 pins_q;
    scs_pkg::scs_mode_e                 mode;
    logic                               osc_q;
    logic                               osc_edge;
    logic [scs_pkg::FACTOR_W-1:0]       factor;
    logic [scs_pkg::HALF_CNT_W-1:0]     half_limit;
    logic                               presc_out;
    logic                               osc_prev_r;
    logic                               osc_prev_nxt;
    logic [scs_pkg::HALF_CNT_W-1:0]     half_cnt_r;
    logic [scs_pkg::HALF_CNT_W-1:0]     half_cnt_nxt;
    logic                               sys_clock_r;
    logic                               sys_clock_nxt;
    logic                               pll_enable_r;
    logic                               pll_enable_nxt;
    scs_pkg::scs_mode_e                 mode_r;

    // all clock pins pass two flops before use
    scs_sync u_sync (
        .clk (clk),
        .rst (rst),
        .d   (pins),
        .q   (pins_q)
    );

    // source and divider decode
    always_comb
    begin
        mode     = decode_mode(cfg.clock_source_select, cfg.vco_bypass);
        osc_q    = (cfg.osc_source_select == scs_pkg::OSC_SEL_INTERNAL) ?
                   pins_q.internal_clock_input : pins_q.crystal_input;
        osc_edge = osc_q != osc_prev_r;
        factor   = div_factor(cfg.output_prescaler_value);
        // one full output period is twice the factor in oscillator half periods
        half_limit = 11'((12'(factor) << 1) - 12'h001);
    end

    // half-period counter of the oscillator, runs only while prescaling
    always_comb
    begin
        osc_prev_nxt = osc_q;
        half_cnt_nxt = half_cnt_r;
        if (mode != scs_pkg::MODE_PRESCALE)
        begin
            half_cnt_nxt = scs_pkg::HALF_CNT_RST;
        end
        else if (osc_edge)
        begin
            if (half_cnt_r >= half_limit)
                half_cnt_nxt = scs_pkg::HALF_CNT_RST;
            else
                half_cnt_nxt = half_cnt_r + 11'h001;
        end
    end

    // prescaled waveform: high for the first factor half periods
    always_comb
    begin
        if (factor == 11'h001)
            presc_out = osc_q;
        else
            presc_out = {1'b0, half_cnt_r} < {1'b0, factor};
    end

    // output multiplexer
    always_comb
    begin
        pll_enable_nxt = 1'b0;
        case (mode)
            scs_pkg::MODE_DIRECT:   sys_clock_nxt = pins_q.direct_clock_input;
            scs_pkg::MODE_PRESCALE: sys_clock_nxt = presc_out;
            scs_pkg::MODE_PLL:
            begin
                sys_clock_nxt  = pins_q.pll_clock_input;
                pll_enable_nxt = 1'b1;
            end
            scs_pkg::MODE_WAKEUP:   sys_clock_nxt = pins_q.wakeup_clock_input;
            default:                sys_clock_nxt = scs_pkg::SYS_CLOCK_RST;
        endcase
    end

    // state registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            osc_prev_r   <= scs_pkg::PIN_RST;
            half_cnt_r   <= scs_pkg::HALF_CNT_RST;
            sys_clock_r  <= scs_pkg::SYS_CLOCK_RST;
            pll_enable_r <= scs_pkg::PLL_ENABLE_RST;
            mode_r       <= scs_pkg::MODE_WAKEUP;
        end
        else
        begin
            osc_prev_r   <= osc_prev_nxt;
            half_cnt_r   <= half_cnt_nxt;
            sys_clock_r  <= sys_clock_nxt;
            pll_enable_r <= pll_enable_nxt;
            mode_r       <= mode;
        end
    end

    assign sys_clock      = sys_clock_r;
    assign pll_enable     = pll_enable_r;
    assign sys_clock_mode = mode_r;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence direct_held_s;
        mode == scs_pkg::MODE_DIRECT;
    endsequence

    sequence presc_unity_s;
        (mode == scs_pkg::MODE_PRESCALE) && (factor == 11'h001);
    endsequence

    // dividing prescaler, factor above one
    sequence presc_divide_s;
        (mode == scs_pkg::MODE_PRESCALE) && (factor != 11'h001);
    endsequence

    direct_follow_a: assert property (direct_held_s |=>
        sys_clock == $past(pins_q.direct_clock_input))
        else $error("direct mode output does not follow direct input");

    // two direct cycles so both output samples come from the direct pin
    direct_duty_a: assert property ((direct_held_s ##1 direct_held_s) |=>
        ($rose(sys_clock) == ($past(pins_q.direct_clock_input) &&
                              !$past(pins_q.direct_clock_input, 2))))
        else $error("direct mode edges do not track input edges");

    unity_follow_a: assert property (presc_unity_s |=> sys_clock == $past(osc_q))
        else $error("unity prescale output does not follow oscillator");

    crystal_unity_a: assert property ((presc_unity_s and
        (cfg.osc_source_select != scs_pkg::OSC_SEL_INTERNAL)) |=>
        sys_clock == $past(pins_q.crystal_input))
        else $error("crystal bypass at factor one differs from input");

    presc_high_a: assert property ((presc_divide_s and
        ({1'h0, half_cnt_r} < {1'h0, factor})) |=> sys_clock)
        else $error("prescaled output low in its high phase");

    presc_low_a: assert property ((presc_divide_s and
        ({1'h0, half_cnt_r} >= {1'h0, factor})) |=> !sys_clock)
        else $error("prescaled output high in its low phase");

    count_hold_a: assert property ((mode != scs_pkg::MODE_PRESCALE) |=>
        half_cnt_r == scs_pkg::HALF_CNT_RST)
        else $error("half-period counter not held outside prescale mode");

    reserved_low_a: assert property ((mode == scs_pkg::MODE_RESERVED) |=>
        (!sys_clock && !pll_enable))
        else $error("reserved select does not park the output low");

    count_wrap_a: assert property ((mode == scs_pkg::MODE_PRESCALE && osc_edge &&
        half_cnt_r >= half_limit) |=> half_cnt_r == scs_pkg::HALF_CNT_RST)
        else $error("half-period counter did not wrap at limit");

    count_step_a: assert property ((mode == scs_pkg::MODE_PRESCALE && osc_edge &&
        half_cnt_r < half_limit) |=> half_cnt_r == $past(half_cnt_r) + 11'h001)
        else $error("half-period counter did not step on oscillator edge");

    pll_enable_a: assert property ((mode == scs_pkg::MODE_PLL) |=> pll_enable
        && sys_clock == $past(pins_q.pll_clock_input))
        else $error("pll mode not enabled or not selected");

    wake_follow_a: assert property ((mode == scs_pkg::MODE_WAKEUP) |=>
        (!pll_enable && sys_clock == $past(pins_q.wakeup_clock_input)))
        else $error("wakeup mode output does not follow wakeup clock");

    max_divide_a: assert property ((cfg.output_prescaler_value == 10'h3FF) |->
        factor == 11'(scs_pkg::MAX_DIVIDE))
        else $error("largest prescaler value does not give largest divide");

endmodule

`default_nettype wire

// File: hdl/scs_pkg.sv
// Purpose: shared constants and types for the system clock source selector
// Assumes: one 50 MHz sampling clock; clock pins are sampled, not used as clocks
// Notes:   every encoding, width and reset value of the block lives here
`default_nettype none

package scs_pkg;

    // sampling clock
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;

    // clock source select encodings
    localparam logic [1:0] SEL_WAKEUP     = 2'h0;
    localparam logic [1:0] SEL_RESERVED   = 2'h1;
    localparam logic [1:0] SEL_PLL_PRESC  = 2'h2;
    localparam logic [1:0] SEL_DIRECT     = 2'h3;
    localparam logic       VCO_BYPASS_ON  = 1'h1;
    localparam logic       OSC_SEL_INTERNAL = 1'h1;

    // prescaler field and half-period counter
    localparam int PRESC_W    = 10;
    localparam int FACTOR_W   = 11;
    localparam int HALF_CNT_W = 11;
    localparam int MAX_DIVIDE = 1024;

    // reset values
    localparam logic                  SYS_CLOCK_RST  = 1'h0;
    localparam logic                  PLL_ENABLE_RST = 1'h0;
    localparam logic [HALF_CNT_W-1:0] HALF_CNT_RST   = 11'h000;
    localparam logic                  PIN_RST        = 1'h0;

    typedef enum logic [2:0] {
        MODE_WAKEUP,
        MODE_RESERVED,
        MODE_PLL,
        MODE_PRESCALE,
        MODE_DIRECT
    } scs_mode_e;

    // configuration from the controlling side
    typedef struct packed {
        logic [1:0]         clock_source_select;
        logic               vco_bypass;
        logic               osc_source_select;
        logic [PRESC_W-1:0] output_prescaler_value;
    } scs_cfg_s;

    // clock pins and internal sources, all asynchronous to clk
    typedef struct packed {
        logic direct_clock_input;
        logic crystal_input;
        logic internal_clock_input;
        logic wakeup_clock_input;
        logic pll_clock_input;
    } scs_pins_s;

endpackage

`default_nettype wire

// File: hdl/scs_sync.sv
// Purpose: two-stage synchroniser for the clock source pins
// Assumes: inputs are asynchronous to clk
// Notes:   first stage feeds only the second stage
`default_nettype none

module scs_sync (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire scs_pkg::scs_pins_s d,
    output var  scs_pkg::scs_pins_s q
);

    scs_pkg::scs_pins_s meta_r;
    scs_pkg::scs_pins_s meta_nxt;
    scs_pkg::scs_pins_s q_r;
    scs_pkg::scs_pins_s q_nxt;

    // shift pins through two stages
    always_comb
    begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= '{default: scs_pkg::PIN_RST};
            q_r    <= '{default: scs_pkg::PIN_RST};
        end
        else
        begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q = q_r;

endmodule

`default_nettype wire
